// ### src/lpm_pkg.sv
package lpm_pkg;

    // Register offsets of the plain register port
    localparam logic [3:0] LPM_OFS_CTRL   = 4'h0;
    localparam logic [3:0] LPM_OFS_RTC    = 4'h1;
    localparam logic [3:0] LPM_OFS_STATUS = 4'h2;

    // Control register field positions
    localparam int LPM_CTRL_HALT_PERMIT = 0;
    localparam int LPM_CTRL_DBG_PERMIT  = 1;
    localparam int LPM_CTRL_LV_DETECT   = 2;
    localparam int LPM_CTRL_LV_STOP     = 3;
    localparam int LPM_CTRL_OSC_KEEP    = 4;
    localparam int LPM_CTRL_IRC_KEEP    = 5;
    localparam logic [7:0] LPM_CTRL_RESET = 8'h00;
    localparam logic [2:0] LPM_RTC_PS_OFF = 3'h0;

    // Reset vector location pair
    localparam logic [15:0] LPM_VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] LPM_VEC_LO_ADDR = 16'hFFFF;

    // Wake settle time before the core fetches again
    localparam int LPM_CLK_PERIOD_NS   = 10;
    localparam int LPM_WAKE_SETTLE_NS  = 100;
    localparam int LPM_WAKE_SETTLE_CYC =
        (LPM_WAKE_SETTLE_NS + LPM_CLK_PERIOD_NS - 1) / LPM_CLK_PERIOD_NS;

    // Wake source indices
    localparam int LPM_WK_IRQ    = 0;
    localparam int LPM_WK_KBD    = 1;
    localparam int LPM_WK_SERIAL = 2;
    localparam int LPM_WK_ADC    = 3;
    localparam int LPM_WK_CMP    = 4;
    localparam int LPM_WK_LOWV   = 5;
    localparam int LPM_WK_RTI    = 6;
    localparam int LPM_WK_NUM    = 7;

    typedef enum logic [3:0] {
        LPM_FETCH_HI, LPM_FETCH_LO, LPM_FETCH_DONE, LPM_RUN,
        LPM_WAIT, LPM_STOP, LPM_WAKE, LPM_DEBUG
    } lpm_state_type;

    typedef enum logic [1:0] {
        LPM_CMD_BACKGROUND, LPM_CMD_MEM_STATUS, LPM_CMD_OTHER
    } lpm_cmd_type;

    // Clock gate enables
    typedef struct packed {
        logic core;
        logic bus;
        logic dbg;
        logic osc;
        logic irc;
        logic rtc;
    } lpm_clk_type;

    // Standby controls
    typedef struct packed {
        logic reg_standby;
        logic clk_unit_standby;
        logic adc_standby;
    } lpm_pwr_type;

    // Answer to a debug command
    typedef struct packed {
        logic valid;
        logic accept;
        logic err_lowpower;
        logic mem_go;
    } lpm_resp_type;

endpackage

// ### src/lpm_ctrl.sv
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// - After reset fetch start address from FFFE/FFFF high first, regulator full.
// - Idle instruction stops the core clock.
// - Entering wait clears the core interrupt mask bit.
// - In wait bus clocks run, regulation full, only core clock gated.
// - Interrupt in wait restarts core clock and resumes with stacking.
// - In wait only background and memory-status debug commands are accepted.
// - Memory-status commands in wait, or in stop with debug kept, skip access, report low-power error.
// - Background command in wait wakes device into active debug.
// - Stop3 entered only on halt with halt permit bit set.
// - Stop3 halts all clocks; oscillator and reference clock kept on request.
// - In stop3 clock unit, regulator and converter go to standby.
// - Stop3 retains all register, logic and memory state.
// - Stop3 exits by reset or one of seven listed interrupt sources.
// - Reset exit fetches reset vector; interrupt exit takes interrupt vector.
// - Real-time clock disabled while prescale select is zero; it may wake stop3.
// - Active debug from run only while debug permit bit set.
// - Debug permit at halt keeps debug clocks and full regulation in stop.
// - Stop with debug: background wakes to active debug, then all commands.
// - Low-voltage detect and stop enable at halt keep regulator active.
module lpm_ctrl (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Register port
    input  wire logic [3:0]           i_addr,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic [7:0]                o_rdata,
    // Core side
    input  wire logic                 i_core_idle,
    input  wire logic                 i_core_halt,
    input  wire logic                 i_int_req,
    output logic                      o_core_start,
    output logic [15:0]               o_start_addr,
    output logic                      o_core_resume,
    output logic                      o_clear_imask,
    // Vector fetch port
    output logic                      o_vec_rd,
    output logic [15:0]               o_vec_addr,
    input  wire logic [7:0]           i_vec_rdata,
    // Stop wake sources
    input  wire logic [6:0]           i_wake_src,
    // Debug controller side
    input  wire logic                 i_dbg_cmd_valid,
    input  wire lpm_pkg::lpm_cmd_type i_dbg_cmd,
    input  wire logic                 i_dbg_go,
    output lpm_pkg::lpm_resp_type     o_dbg_resp,
    output logic                      o_active_debug,
    // Clock and power controls
    output lpm_pkg::lpm_clk_type      o_clk_en,
    output lpm_pkg::lpm_pwr_type      o_pwr,
    output logic                      o_retain
);
    import lpm_pkg::*;

    typedef struct packed {
        lpm_state_type st;
        logic [3:0]    cnt;
        logic [7:0]    pc_hi;
        logic [15:0]   start_addr;
        logic          core_start;
        logic          core_resume;
        logic          clear_imask;
        logic          vec_rd;
        logic [15:0]   vec_addr;
        logic [7:0]    ctrl;
        logic [2:0]    rtc_ps;
        logic          dbg_kept;
        logic          reg_kept;
        logic [7:0]    rdata;
        lpm_resp_type  resp;
        lpm_clk_type   clk;
        lpm_pwr_type   pwr;
    } lpm_all_type;

    localparam logic [3:0] SETTLE_LAST = 4'(LPM_WAKE_SETTLE_CYC - 1);

    lpm_all_type r;
    lpm_all_type next_r;

    logic halt_permit;
    logic dbg_permit;
    logic stop_wake;
    logic rtc_on;

    //////////////////////////////////////////////////////////////////////////
    // Decoded control bits
    assign halt_permit = r.ctrl[LPM_CTRL_HALT_PERMIT];
    assign dbg_permit  = r.ctrl[LPM_CTRL_DBG_PERMIT];
    assign rtc_on      = (r.rtc_ps != LPM_RTC_PS_OFF);

    // Stop wake from the listed sources only, real-time one when counting
    always_comb begin
        stop_wake = i_wake_src[LPM_WK_IRQ] | i_wake_src[LPM_WK_KBD]
                  | i_wake_src[LPM_WK_SERIAL] | i_wake_src[LPM_WK_ADC]
                  | i_wake_src[LPM_WK_CMP] | i_wake_src[LPM_WK_LOWV]
                  | (i_wake_src[LPM_WK_RTI] & rtc_on);
    end

    //////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_r             = r;
        next_r.core_start  = 1'b0;
        next_r.core_resume = 1'b0;
        next_r.clear_imask = 1'b0;
        next_r.vec_rd      = 1'b0;
        next_r.resp        = '0;
        next_r.rdata       = 8'h00;

        // Register writes
        if (i_wr) begin
            unique case (i_addr)
                LPM_OFS_CTRL: next_r.ctrl   = i_wdata;
                LPM_OFS_RTC:  next_r.rtc_ps = i_wdata[2:0];
                default: ;
            endcase
        end

        // Register reads, data in the following cycle
        if (i_rd) begin
            unique case (i_addr)
                LPM_OFS_CTRL:   next_r.rdata = r.ctrl;
                LPM_OFS_RTC:    next_r.rdata = {5'h00, r.rtc_ps};
                LPM_OFS_STATUS: next_r.rdata = {r.pwr.reg_standby, r.dbg_kept,
                                                r.reg_kept, 1'b0, r.st};
                default:        next_r.rdata = 8'h00;
            endcase
        end

        // Mode sequencing
        unique case (r.st)
            LPM_FETCH_HI: begin
                next_r.vec_rd   = 1'b1;
                next_r.vec_addr = LPM_VEC_HI_ADDR;
                next_r.st       = LPM_FETCH_LO;
            end
            LPM_FETCH_LO: begin
                next_r.pc_hi    = i_vec_rdata;
                next_r.vec_rd   = 1'b1;
                next_r.vec_addr = LPM_VEC_LO_ADDR;
                next_r.st       = LPM_FETCH_DONE;
            end
            LPM_FETCH_DONE: begin
                next_r.start_addr = {r.pc_hi, i_vec_rdata};
                next_r.core_start = 1'b1;
                next_r.st         = LPM_RUN;
            end
            LPM_RUN: begin
                if (i_dbg_cmd_valid) begin
                    next_r.resp.valid  = 1'b1;
                    next_r.resp.mem_go = (i_dbg_cmd == LPM_CMD_MEM_STATUS);
                    if (i_dbg_cmd == LPM_CMD_BACKGROUND) begin
                        next_r.resp.accept = dbg_permit;
                        if (dbg_permit)
                            next_r.st = LPM_DEBUG;
                    end else begin
                        next_r.resp.accept = 1'b1;
                    end
                end else if (i_core_idle) begin
                    next_r.clear_imask = 1'b1;
                    next_r.st          = LPM_WAIT;
                end else if (i_core_halt && halt_permit) begin
                    next_r.clear_imask = 1'b1;
                    next_r.dbg_kept    = dbg_permit;
                    next_r.reg_kept    = dbg_permit
                        | (r.ctrl[LPM_CTRL_LV_DETECT] & r.ctrl[LPM_CTRL_LV_STOP]);
                    next_r.st          = LPM_STOP;
                end
            end
            LPM_WAIT: begin
                if (i_dbg_cmd_valid) begin
                    next_r.resp.valid = 1'b1;
                    unique case (i_dbg_cmd)
                        LPM_CMD_BACKGROUND: begin
                            next_r.resp.accept = 1'b1;
                            next_r.st          = LPM_DEBUG;
                        end
                        LPM_CMD_MEM_STATUS: begin
                            next_r.resp.accept       = 1'b1;
                            next_r.resp.err_lowpower = 1'b1;
                        end
                        default: next_r.resp.accept = 1'b0;
                    endcase
                end else if (i_int_req) begin
                    next_r.core_resume = 1'b1;
                    next_r.st          = LPM_RUN;
                end
            end
            LPM_STOP: begin
                // State is simply held; only cnt and, on a source wake, dbg_kept are cleared here
                if (i_dbg_cmd_valid && r.dbg_kept) begin
                    next_r.resp.valid = 1'b1;
                    unique case (i_dbg_cmd)
                        LPM_CMD_BACKGROUND: begin
                            next_r.resp.accept = 1'b1;
                            next_r.cnt         = 4'h0;
                            next_r.st          = LPM_WAKE;
                        end
                        LPM_CMD_MEM_STATUS: begin
                            next_r.resp.accept       = 1'b1;
                            next_r.resp.err_lowpower = 1'b1;
                        end
                        default: next_r.resp.accept = 1'b0;
                    endcase
                end else if (stop_wake) begin
                    next_r.dbg_kept = 1'b0;
                    next_r.cnt      = 4'h0;
                    next_r.st       = LPM_WAKE;
                end
            end
            LPM_WAKE: begin
                // Regulation and all clocks but the core clock back on; core clock stays gated while settling before core goes
                if (r.cnt == SETTLE_LAST) begin
                    if (r.dbg_kept) begin
                        next_r.st = LPM_DEBUG;
                    end else begin
                        next_r.core_resume = 1'b1;
                        next_r.st          = LPM_RUN;
                    end
                    next_r.dbg_kept = 1'b0;
                    next_r.reg_kept = 1'b0;
                end else begin
                    next_r.cnt = r.cnt + 4'h1;
                end
            end
            LPM_DEBUG: begin
                if (i_dbg_cmd_valid) begin
                    next_r.resp.valid  = 1'b1;
                    next_r.resp.accept = 1'b1;
                    next_r.resp.mem_go = (i_dbg_cmd == LPM_CMD_MEM_STATUS);
                end else if (i_dbg_go) begin
                    next_r.core_resume = 1'b1;
                    next_r.st          = LPM_RUN;
                end
            end
            default: next_r.st = LPM_FETCH_HI;
        endcase

        // Clock gating follows the next mode
        next_r.clk.bus  = 1'b1;
        next_r.clk.core = 1'b1;
        next_r.clk.dbg  = 1'b1;
        next_r.clk.osc  = 1'b1;
        next_r.clk.irc  = 1'b1;
        next_r.clk.rtc  = (next_r.rtc_ps != LPM_RTC_PS_OFF);
        next_r.pwr      = '0;
        unique case (next_r.st)
            LPM_WAIT: next_r.clk.core = 1'b0;
            LPM_STOP: begin
                next_r.clk.core = 1'b0;
                next_r.clk.bus  = 1'b0;
                next_r.clk.dbg  = next_r.dbg_kept;
                next_r.clk.osc  = next_r.ctrl[LPM_CTRL_OSC_KEEP];
                next_r.clk.irc  = next_r.ctrl[LPM_CTRL_IRC_KEEP];
                next_r.pwr.reg_standby      = ~next_r.reg_kept;
                next_r.pwr.clk_unit_standby = 1'b1;
                next_r.pwr.adc_standby      = 1'b1;
            end
            LPM_WAKE: next_r.clk.core = 1'b0;
            default: ;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r            <= '0;
            r.st         <= LPM_FETCH_HI;
            r.ctrl       <= LPM_CTRL_RESET;
            r.clk.bus    <= 1'b1;
            r.clk.core   <= 1'b1;
            r.clk.dbg    <= 1'b1;
            r.clk.osc    <= 1'b1;
            r.clk.irc    <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_rdata        = r.rdata;
    assign o_core_start   = r.core_start;
    assign o_start_addr   = r.start_addr;
    assign o_core_resume  = r.core_resume;
    assign o_clear_imask  = r.clear_imask;
    assign o_vec_rd       = r.vec_rd;
    assign o_vec_addr     = r.vec_addr;
    assign o_dbg_resp     = r.resp;
    assign o_active_debug = (r.st == LPM_DEBUG);
    assign o_clk_en       = r.clk;
    assign o_pwr          = r.pwr;
    assign o_retain       = (r.st == LPM_STOP);

endmodule

// ### sim/lpm_vec_mem.sv
`timescale 1ns/1ps

module lpm_vec_mem
#(
    parameter logic [7:0] VEC_HI = 8'h00,
    parameter logic [7:0] VEC_LO = 8'h00
)
(
    input  wire logic        i_clk,
    input  wire logic        i_vec_rd,
    input  wire logic [15:0] i_vec_addr,
    output logic      [7:0]  o_vec_rdata
);
    import lpm_pkg::*;

    logic [7:0] junk;

    initial junk = 8'h5A;

    // Churning garbage while no read stands
    always @(posedge i_clk) begin
        junk <= ~junk;
    end

    // Byte answered while the read stands, where the fetch captures it
    assign o_vec_rdata = !i_vec_rd ? junk
                       : (i_vec_addr == LPM_VEC_HI_ADDR) ? VEC_HI : VEC_LO;
endmodule

// ### sim/lpm_ctrl_properties.sv
`timescale 1ns/1ps

module lpm_ctrl_chk (
    input wire logic                 i_clk,
    input wire logic                 i_rst_n,
    input wire logic [3:0]           i_addr,
    input wire logic [7:0]           i_wdata,
    input wire logic                 i_wr,
    input wire logic                 i_core_halt,
    input wire logic [6:0]           i_wake_src,
    input wire logic                 i_dbg_cmd_valid,
    input wire logic                 o_core_start,
    input wire logic                 o_core_resume,
    input wire logic                 o_clear_imask,
    input wire logic                 o_vec_rd,
    input wire logic [15:0]          o_vec_addr,
    input wire lpm_pkg::lpm_clk_type o_clk_en,
    input wire lpm_pkg::lpm_pwr_type o_pwr,
    input wire logic                 o_retain
);
    import lpm_pkg::*;
    localparam int SETTLE = LPM_WAKE_SETTLE_CYC;
    logic [7:0] ctl;
    logic [2:0] ps;

    // Shadow of control and prescale fields
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl <= LPM_CTRL_RESET;
            ps  <= LPM_RTC_PS_OFF;
        end else if (i_wr) begin
            if (i_addr == LPM_OFS_CTRL) ctl <= i_wdata;
            if (i_addr == LPM_OFS_RTC) ps <= i_wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_VEC_ORDER: assert property (o_vec_rd && o_vec_addr == LPM_VEC_HI_ADDR |=>
        o_vec_rd && o_vec_addr == LPM_VEC_LO_ADDR ##1 o_core_start && !o_pwr.reg_standby)
        else $error("vector fetch order wrong");
    AST_IDLE_GATE: assert property (o_clear_imask |-> !o_clk_en.core)
        else $error("core clock runs after entry");
    AST_WAIT_BUS: assert property (!o_clk_en.core && !o_retain |->
        o_clk_en.bus && !o_pwr.reg_standby) else $error("wait lost bus clock");
    AST_HALT_PERMIT: assert property ($rose(o_retain) |->
        ctl[LPM_CTRL_HALT_PERMIT] && $past(i_core_halt) && o_clear_imask)
        else $error("stop entered without permit");
    AST_STOP_CLOCKS: assert property (o_retain |->
        !o_clk_en.core && !o_clk_en.bus && o_pwr.clk_unit_standby && o_pwr.adc_standby &&
        o_clk_en.osc == ctl[LPM_CTRL_OSC_KEEP] && o_clk_en.irc == ctl[LPM_CTRL_IRC_KEEP])
        else $error("stop clocks wrong");
    AST_STOP_REG: assert property (o_retain |->
        o_clk_en.dbg == ctl[LPM_CTRL_DBG_PERMIT] && o_pwr.reg_standby !=
        (ctl[LPM_CTRL_DBG_PERMIT] || ctl[LPM_CTRL_LV_DETECT] && ctl[LPM_CTRL_LV_STOP]))
        else $error("stop regulator wrong");
    AST_RTC_OFF: assert property (o_retain && ps == LPM_RTC_PS_OFF &&
        i_wake_src == 7'h40 && !i_dbg_cmd_valid |=> o_retain)
        else $error("disabled rtc woke device");
    AST_WAKE_EXIT: assert property (o_retain && i_wake_src[5:0] != 6'h00 &&
        !i_dbg_cmd_valid |=> !o_retain) else $error("wake source ignored");
    AST_WAKE_SETTLE: assert property ($fell(o_retain) && !$past(i_dbg_cmd_valid) |->
        !o_clk_en.core && !o_pwr.reg_standby ##SETTLE o_core_resume && o_clk_en.core)
        else $error("core resumed at wrong time");
endmodule

bind lpm_ctrl lpm_ctrl_chk chk_u (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_core_halt,
    .i_wake_src, .i_dbg_cmd_valid, .o_core_start, .o_core_resume, .o_clear_imask, .o_vec_rd,
    .o_vec_addr, .o_clk_en, .o_pwr, .o_retain);

// ### sim/lpm_ctrl_tb.sv
`timescale 1ns/1ps

module lpm_ctrl_tb;
    import lpm_pkg::*;
    typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e;} lpm_row_type;
    localparam logic [7:0] VH = 8'hC3;
    localparam logic [7:0] VL = 8'h1E;
    logic i_clk = 1'b0, i_rst_n, i_wr, i_rd, i_core_idle, i_core_halt, i_int_req;
    logic i_dbg_cmd_valid, i_dbg_go, o_core_start, o_core_resume, o_clear_imask;
    logic o_vec_rd, o_active_debug, o_retain;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, i_vec_rdata, d;
    logic [15:0] o_start_addr, o_vec_addr;
    logic [6:0] i_wake_src;
    lpm_cmd_type i_dbg_cmd;
    lpm_resp_type o_dbg_resp;
    lpm_clk_type o_clk_en;
    lpm_pwr_type o_pwr;
    int n_mismatch = 0, num_checks = 0;
    lpm_row_type rows [4] = '{'{4'h0, 8'h2A, 8'h2A}, '{4'h1, 8'h05, 8'h05},
                              '{4'h2, 8'hFF, 8'h03}, '{4'hF, 8'hFF, 8'h00}};

    lpm_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core_idle(i_core_idle),
        .i_core_halt(i_core_halt), .i_int_req(i_int_req), .o_core_start(o_core_start),
        .o_start_addr(o_start_addr), .o_core_resume(o_core_resume),
        .o_clear_imask(o_clear_imask), .o_vec_rd(o_vec_rd), .o_vec_addr(o_vec_addr),
        .i_vec_rdata(i_vec_rdata), .i_wake_src(i_wake_src), .i_dbg_cmd_valid(i_dbg_cmd_valid),
        .i_dbg_cmd(i_dbg_cmd), .i_dbg_go(i_dbg_go), .o_dbg_resp(o_dbg_resp),
        .o_active_debug(o_active_debug), .o_clk_en(o_clk_en), .o_pwr(o_pwr),
        .o_retain(o_retain));
    lpm_vec_mem #(.VEC_HI(VH), .VEC_LO(VL)) mem_u (.i_clk(i_clk), .i_vec_rd(o_vec_rd),
        .i_vec_addr(o_vec_addr), .o_vec_rdata(i_vec_rdata));

    always #5 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] w);
        @(posedge i_clk);
        i_addr <= a; i_wdata <= w; i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task cpu(input logic idle, input logic halt);
        @(posedge i_clk);
        i_core_idle <= idle; i_core_halt <= halt;
        @(posedge i_clk);
        i_core_idle <= 1'b0; i_core_halt <= 1'b0;
        #1;
    endtask
    task cmd(input lpm_cmd_type c, input logic [3:0] e);
        @(posedge i_clk);
        i_dbg_cmd_valid <= 1'b1; i_dbg_cmd <= c;
        @(posedge i_clk);
        i_dbg_cmd_valid <= 1'b0;
        #1 chk("resp", o_dbg_resp, e);
    endtask
    // Bounded wait on resume, start or debug entry
    task wt(input int s, input string n);
        int k;
        k = 0;
        while (k < 40 && !(s == 0 ? o_core_resume === 1'b1 : s == 1 ? o_core_start === 1'b1
                                  : o_active_debug === 1'b1)) begin
            @(posedge i_clk);
            #1 k++;
        end
        chk(n, k < 40, 1'b1);
    endtask
    task go;
        @(posedge i_clk);
        i_dbg_go <= 1'b1;
        @(posedge i_clk);
        i_dbg_go <= 1'b0;
        #1 wt(0, "go_resume");
    endtask
    task rst;
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        #1 chk("rst_clk", o_clk_en, 6'h3E);
        chk("rst_pwr", o_pwr, 3'h0);
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        wt(1, "start");
        chk("start_addr", o_start_addr, {VH, VL});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst_n = 1'b0;
        {i_wr, i_rd, i_core_idle, i_core_halt, i_int_req, i_dbg_cmd_valid, i_dbg_go} = 7'h00;
        {i_addr, i_wdata, i_wake_src} = 19'h00000;
        i_dbg_cmd = LPM_CMD_BACKGROUND;
        rst();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chk("rdata", d, rows[i].e);
        end
        // Wait mode entered, then interrupt
        wr(LPM_OFS_CTRL, 8'h00);
        wr(LPM_OFS_RTC, 8'h00);
        cpu(1'b1, 1'b0);
        chk("imask", o_clear_imask, 1'b1);
        chk("wait_clk", {o_clk_en.core, o_clk_en.bus, o_pwr.reg_standby}, 3'h2);
        @(posedge i_clk) i_int_req <= 1'b1;
        wt(0, "int_resume");
        @(posedge i_clk) i_int_req <= 1'b0;
        #1 chk("core_on", o_clk_en.core, 1'b1);
        // Debug commands in wait
        cpu(1'b1, 1'b0);
        cmd(LPM_CMD_MEM_STATUS, 4'hE);
        cmd(LPM_CMD_OTHER, 4'h8);
        cmd(LPM_CMD_BACKGROUND, 4'hC);
        wt(2, "wait_debug");
        go();
        // Without permits: entry refused, memory access allowed, halt ignored
        cmd(LPM_CMD_BACKGROUND, 4'h8);
        cmd(LPM_CMD_MEM_STATUS, 4'hD);
        cpu(1'b0, 1'b1);
        chk("no_debug", o_active_debug, 1'b0);
        chk("no_stop", o_retain, 1'b0);
        // Disabled real-time clock does not wake
        wr(LPM_OFS_CTRL, 8'h11);
        cpu(1'b0, 1'b1);
        @(posedge i_clk) i_wake_src <= 7'h40;
        repeat (3) @(posedge i_clk);
        #1 chk("rtc_off", o_retain, 1'b1);
        chk("rtc_gate", o_clk_en.rtc, 1'b0);
        @(posedge i_clk) i_wake_src <= 7'h01;
        wt(0, "irq_wake");
        @(posedge i_clk) i_wake_src <= 7'h00;
        wr(LPM_OFS_RTC, 8'h01);
        #1 chk("rtc_clk", o_clk_en.rtc, 1'b1);
        for (int i = 0; i < LPM_WK_NUM; i++) begin
            cpu(1'b0, 1'b1);
            chk("stop", {o_retain, o_pwr, o_clk_en.osc, o_clk_en.irc}, 6'h3E);
            @(posedge i_clk) i_wake_src <= 7'h01 << i;
            wt(0, "src_wake");
            @(posedge i_clk) i_wake_src <= 7'h00;
        end
        rd(LPM_OFS_CTRL);
        chk("held", d, 8'h11);
        // Stop with debug kept
        wr(LPM_OFS_CTRL, 8'h03);
        cpu(1'b0, 1'b1);
        chk("dbg_stop", {o_retain, o_pwr.reg_standby, o_clk_en.dbg}, 3'h5);
        cmd(LPM_CMD_MEM_STATUS, 4'hE);
        cmd(LPM_CMD_BACKGROUND, 4'hC);
        wt(2, "stop_debug");
        cmd(LPM_CMD_OTHER, 4'hC);
        cmd(LPM_CMD_MEM_STATUS, 4'hD);
        go();
        cmd(LPM_CMD_BACKGROUND, 4'hC);
        wt(2, "run_debug");
        go();
        // Low-voltage detect kept, then reset out of stop
        wr(LPM_OFS_CTRL, 8'h0D);
        cpu(1'b0, 1'b1);
        chk("lvd_stop", {o_retain, o_pwr.reg_standby}, 2'h2);
        rst();
        rd(LPM_OFS_CTRL);
        chk("ctrl_rst", d, LPM_CTRL_RESET);
        results();
    end

    // Watchdog against a hang
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
endmodule
